// ===== rtl/fan_pwm_duty_control.sv
/*
   Fan PWM duty controller: start-up full drive, duty source selection
   between the duty register and the analog demand, over-temperature flag,
   shutdown handling, and the fixed-period PWM engine instance.
   Assumes configuration bits and the duty register write port are driven by
   serial interface logic on the same clock, and the demand level by an ADC
   block on the same clock, so none of them is resynchronised here.
*/

// Notes on behaviour
// - constant frequency, duty only from 30 to 100%
// - fixed period near 30 Hz, duty independent
// - high means fan on; 100% stays high
// - one second full drive after reset/shutdown
// - after start, select bit chooses duty source
// - select defaults to analog demand after reset
// - open analog input gives 39.33% duty
// - source change applies from the next period boundary
// - 1.62 V to 2.6 V maps monotonically 30-100%
// - demand below range clamps duty at 30%
// - demand above 2.6 V sets flag, fault low
// - 4-bit code maps linearly 30% to 100%
// - code 0010 equals 39.33% open-input duty
// - shutdown stops drive; exit restarts full period
// - flag and fault clear below full scale
// - drive keeps pulsing; only shutdown stops it
module fan_pwm_duty_control #(
   parameter int STEP_CYCLES  = fan_pwm_pkg::STEP_CYCLES_DEF,
   parameter int START_CYCLES = fan_pwm_pkg::START_CYCLES_DEF
) (
   input  logic                     ref_clk_in,
   input  logic                     sys_rst_in,
   input  logic                     ce_in,
   input  logic                     shutdown_request_in,
   input  logic                     duty_source_select_in,
   input  fan_pwm_pkg::duty_write_t duty_write_in,
   input  fan_pwm_pkg::demand_t     demand_in,
   output logic [3:0]               fan_duty_setting_out,
   output logic                     pwm_drive_out,
   output logic                     overtemp_flag_out,
   output logic                     fault_drive_out,
   output logic                     fault_oe_out,
   output logic                     startup_active_out,
   output logic                     period_start_out
);
   import fan_pwm_pkg::*;

   localparam logic [START_W-1:0] START_LAST = START_W'(START_CYCLES - 1);

   ctrl_state_t s_reg;
   ctrl_state_t s_next;
   duty_t       analog_duty;
   duty_t       reg_duty;
   logic        run;

   function automatic duty_t code_to_duty(input logic [3:0] code);
      code_to_duty = DUTY_MIN + duty_t'(code) * DUTY_STEP;
   endfunction

   // analog map; the top end is forced so the ceiling is exactly full scale
   always_comb
   begin
      logic [8:0]  span;
      logic [20:0] prod;
      span = '0;
      prod = '0;
      if (demand_in.open)
      begin
         analog_duty = code_to_duty(CODE_OPEN);
      end
      else if (demand_in.level <= LEVEL_LO)
      begin
         analog_duty = DUTY_MIN;
      end
      else if (demand_in.level >= LEVEL_HI)
      begin
         analog_duty = DUTY_FULL;
      end
      else
      begin
         span        = demand_in.level - LEVEL_LO;
         prod        = {12'h000, span} * {9'h000, ANALOG_GAIN};
         analog_duty = DUTY_MIN + prod[GAIN_SHIFT +: 9];
      end
   end

   assign reg_duty = code_to_duty(s_reg.duty_code);

   always_comb
   begin
      s_next = s_reg;
      // the serial side stays alive in shutdown, so the register still takes writes
      if (duty_write_in.wr)
      begin
         s_next.duty_code = duty_write_in.code;
      end
      s_next.select = duty_source_select_in;
      case (s_reg.phase)
         PH_OFF:
         begin
            s_next.duty_cmd = DUTY_FULL;
            s_next.overtemp = 1'b0;
            if (!shutdown_request_in)
            begin
               s_next.phase     = PH_START;
               s_next.start_cnt = '0;
            end
         end
         PH_START:
         begin
            s_next.duty_cmd = DUTY_FULL;
            if (shutdown_request_in)
            begin
               s_next.phase = PH_OFF;
            end
            else if (s_reg.start_cnt == START_LAST)
            begin
               s_next.phase = PH_RUN;
            end
            else
            begin
               s_next.start_cnt = s_reg.start_cnt + START_W'(1);
            end
         end
         PH_RUN:
         begin
            if (shutdown_request_in)
            begin
               s_next.phase = PH_OFF;
            end
            else if (s_reg.select)
            begin
               s_next.duty_cmd = reg_duty;
            end
            else
            begin
               s_next.duty_cmd = analog_duty;
            end
         end
         default:
         begin
            s_next.phase = PH_OFF;
         end
      endcase
      if (s_reg.phase != PH_OFF && !shutdown_request_in)
      begin
         // level-following: clears as soon as demand drops back
         s_next.overtemp = !demand_in.open && (demand_in.level > LEVEL_HI);
      end
      else
      begin
         // a suspended device reports no fault, whatever the demand
         s_next.overtemp = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         s_reg.phase     <= PH_START;
         s_reg.start_cnt <= '0;
         s_reg.duty_code <= CODE_RESET;
         s_reg.select    <= 1'b0;
         s_reg.duty_cmd  <= DUTY_FULL;
         s_reg.overtemp  <= 1'b0;
      end
      else if (ce_in)
      begin
         s_reg <= s_next;
      end
   end

   assign run = (s_reg.phase != PH_OFF);

   fan_pwm_core #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_core (
      .ref_clk_in       (ref_clk_in),
      .sys_rst_in       (sys_rst_in),
      .ce_in            (ce_in),
      .run_in           (run),
      .duty_in          (s_reg.duty_cmd),
      .pwm_out          (pwm_drive_out),
      .period_start_out (period_start_out)
   );

   assign fan_duty_setting_out = s_reg.duty_code;
   assign overtemp_flag_out    = s_reg.overtemp;
   // open-drain fault: only ever pulls low
   assign fault_drive_out      = 1'b0;
   assign fault_oe_out         = s_reg.overtemp;
   assign startup_active_out   = (s_reg.phase == PH_START);

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   property p_reset_default;
      sys_rst_in |=> (s_reg.select == 1'b0) && (s_reg.phase == PH_START);
   endproperty
   a_reset_default: assert property (disable iff (1'b0) p_reset_default)
      else $error("reset did not select analog control and start-up");

   property p_startup_full;
      (s_reg.phase == PH_START) |-> (s_reg.duty_cmd == DUTY_FULL);
   endproperty
   a_startup_full: assert property (p_startup_full)
      else $error("start-up period not at full duty");

   property p_leave_shutdown;
      (ce_in && s_reg.phase == PH_OFF && !shutdown_request_in)
         |=> (s_reg.phase == PH_START) && (s_reg.start_cnt == '0);
   endproperty
   a_leave_shutdown: assert property (p_leave_shutdown)
      else $error("leaving shutdown did not restart the full-on period");

   property p_shutdown_low;
      (ce_in && shutdown_request_in) ##1 ce_in |=> !pwm_drive_out;
   endproperty
   a_shutdown_low: assert property (p_shutdown_low)
      else $error("drive still active during shutdown");

   property p_run_keeps_run;
      (ce_in && s_reg.phase == PH_RUN && !shutdown_request_in) |=> (s_reg.phase == PH_RUN);
   endproperty
   a_run_keeps_run: assert property (p_run_keeps_run)
      else $error("drive stopped without a shutdown request");

   property p_select_reg;
      (ce_in && s_reg.phase == PH_RUN && s_reg.select && !shutdown_request_in)
         |=> (s_reg.duty_cmd == DUTY_MIN + duty_t'($past(s_reg.duty_code)) * DUTY_STEP);
   endproperty
   a_select_reg: assert property (p_select_reg)
      else $error("register duty not applied in register mode");

   property p_open_default;
      (ce_in && s_reg.phase == PH_RUN && !s_reg.select && demand_in.open
         && !shutdown_request_in) |=> (s_reg.duty_cmd == 9'h076);
   endproperty
   a_open_default: assert property (p_open_default)
      else $error("open demand input did not give 39.33 percent");

   property p_floor;
      (ce_in && s_reg.phase == PH_RUN && !s_reg.select && !demand_in.open
         && demand_in.level < LEVEL_LO && !shutdown_request_in)
         |=> (s_reg.duty_cmd == DUTY_MIN);
   endproperty
   a_floor: assert property (p_floor)
      else $error("low demand not clamped at minimum duty");

   property p_analog_mono;
      (ce_in && $past(ce_in) && s_reg.phase == PH_RUN && $past(s_reg.phase) == PH_RUN
         && !s_reg.select && !$past(s_reg.select) && !shutdown_request_in
         && !demand_in.open && !$past(demand_in.open)
         && demand_in.level >= $past(demand_in.level))
         |=> (s_reg.duty_cmd >= $past(s_reg.duty_cmd));
   endproperty
   a_analog_mono: assert property (p_analog_mono)
      else $error("analog duty map is not monotonic");

   property p_duty_range;
      (s_reg.duty_cmd >= DUTY_MIN) && (s_reg.duty_cmd <= DUTY_FULL);
   endproperty
   a_duty_range: assert property (p_duty_range)
      else $error("commanded duty outside 30 to 100 percent");

   property p_overtemp_set;
      (ce_in && run && !shutdown_request_in && !demand_in.open && demand_in.level > LEVEL_HI)
         |=> overtemp_flag_out && fault_oe_out && !fault_drive_out;
   endproperty
   a_overtemp_set: assert property (p_overtemp_set)
      else $error("over-temperature not flagged");

   property p_overtemp_clear;
      (ce_in && !(demand_in.level > LEVEL_HI && !demand_in.open))
         |=> !overtemp_flag_out && !fault_oe_out;
   endproperty
   a_overtemp_clear: assert property (p_overtemp_clear)
      else $error("over-temperature flag not released");

   property p_overtemp_off;
      (s_reg.phase == PH_OFF) |-> (!overtemp_flag_out && !fault_oe_out);
   endproperty
   a_overtemp_off: assert property (p_overtemp_off)
      else $error("fault reported while shut down");

   property p_start_to_run;
      (ce_in && s_reg.phase == PH_START && s_reg.start_cnt == START_LAST
         && !shutdown_request_in) |=> (s_reg.phase == PH_RUN);
   endproperty
   a_start_to_run: assert property (p_start_to_run)
      else $error("start-up period did not hand over to a duty source");

   property p_write_taken;
      (ce_in && duty_write_in.wr) |=> (fan_duty_setting_out == $past(duty_write_in.code));
   endproperty
   a_write_taken: assert property (p_write_taken)
      else $error("duty register write not taken");

   c_startup_done: cover property (ce_in && s_reg.phase == PH_START ##1 s_reg.phase == PH_RUN);
   c_reg_mode:     cover property (s_reg.phase == PH_RUN && s_reg.select && duty_write_in.wr);
   c_overtemp:     cover property ($rose(overtemp_flag_out));
   c_shutdown:     cover property (s_reg.phase == PH_RUN ##1 s_reg.phase == PH_OFF);
   c_open_input:   cover property (s_reg.phase == PH_RUN && !s_reg.select && demand_in.open);

endmodule

// ===== rtl/fan_pwm_pkg.sv
/*
   Shared constants and types for the fan PWM duty controller: timing figures,
   duty scale, analog demand scaling and the packed state records.
   Assumes a 100 MHz system clock and a demand level already digitised at
   10 mV per count by logic on the same clock.
*/
package fan_pwm_pkg;

   localparam int CLK_HZ     = 100_000_000;
   localparam int PWM_HZ     = 30;
   localparam int START_S    = 1;
   localparam int DUTY_SCALE = 300;
   // one period is DUTY_SCALE slots; each slot is STEP cycles long
   localparam int STEP_CYCLES_DEF  = CLK_HZ / PWM_HZ / DUTY_SCALE;
   localparam int START_CYCLES_DEF = START_S * CLK_HZ;

   localparam int STEP_W  = 14;
   localparam int START_W = 27;

   // duty is counted in slots of 1/300 of the period
   typedef logic [8:0] duty_t;
   localparam duty_t DUTY_MIN  = 9'h05A;
   localparam duty_t DUTY_STEP = 9'h00E;
   localparam duty_t DUTY_FULL = 9'h12C;
   localparam duty_t SLOT_LAST = 9'h12B;

   localparam logic [3:0] CODE_OPEN  = 4'h2;
   localparam logic [3:0] CODE_RESET = 4'h2;

   // demand level in 10 mV counts
   typedef logic [8:0] level_t;
   localparam level_t      LEVEL_LO    = 9'h0A2;
   localparam level_t      LEVEL_HI    = 9'h104;
   // 2194/1024 approximates the 210/98 slope of the analog map
   localparam logic [11:0] ANALOG_GAIN = 12'h892;
   localparam int          GAIN_SHIFT  = 10;

   typedef struct packed {
      logic   open;
      level_t level;
   } demand_t;

   typedef struct packed {
      logic       wr;
      logic [3:0] code;
   } duty_write_t;

   typedef enum logic [1:0] {
      PH_OFF   = 2'b00,
      PH_START = 2'b01,
      PH_RUN   = 2'b10
   } phase_t;

   typedef struct packed {
      phase_t               phase;
      logic [START_W-1:0]   start_cnt;
      logic [3:0]           duty_code;
      logic                 select;
      duty_t                duty_cmd;
      logic                 overtemp;
   } ctrl_state_t;

   typedef struct packed {
      logic                active;
      logic [STEP_W-1:0]   step;
      duty_t               slot;
      duty_t               duty_lat;
      logic                out;
      logic                wrap;
   } core_state_t;

endpackage

// ===== rtl/fan_pwm_core.sv
/*
   Fixed-period PWM engine: a slot prescaler and a slot counter compared
   against a duty value that is latched only at period boundaries.
   Assumes run_in and duty_in come from logic on the same clock.
*/
module fan_pwm_core #(
   parameter int STEP_CYCLES = fan_pwm_pkg::STEP_CYCLES_DEF
) (
   input  logic                ref_clk_in,
   input  logic                sys_rst_in,
   input  logic                ce_in,
   input  logic                run_in,
   input  fan_pwm_pkg::duty_t  duty_in,
   output logic                pwm_out,
   output logic                period_start_out
);
   import fan_pwm_pkg::*;

   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

   core_state_t s_reg;
   core_state_t s_next;

   always_comb
   begin
      s_next        = s_reg;
      s_next.wrap   = 1'b0;
      s_next.active = run_in;
      if (!run_in)
      begin
         // stopped: restart a fresh period when run returns
         s_next.step     = '0;
         s_next.slot     = '0;
         s_next.duty_lat = duty_in;
      end
      else if (s_reg.step == STEP_LAST)
      begin
         s_next.step = '0;
         if (s_reg.slot == SLOT_LAST)
         begin
            s_next.slot     = '0;
            s_next.duty_lat = duty_in;
            s_next.wrap     = 1'b1;
         end
         else
         begin
            s_next.slot = s_reg.slot + 9'h001;
         end
      end
      else
      begin
         s_next.step = s_reg.step + STEP_W'(1);
      end
      if (run_in && !s_reg.active)
      begin
         // reset clears the latch, so the first running cycle must take the duty
         s_next.duty_lat = duty_in;
      end
      // high from period start to compare point; full scale never drops
      s_next.out = run_in && (s_next.slot < s_next.duty_lat);
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         s_reg <= '0;
      end
      else if (ce_in)
      begin
         s_reg <= s_next;
      end
   end

   assign pwm_out          = s_reg.out;
   assign period_start_out = s_reg.wrap;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   property p_out_compare;
      pwm_out == (s_reg.active && (s_reg.slot < s_reg.duty_lat));
   endproperty
   a_out_compare: assert property (p_out_compare)
      else $error("pwm output disagrees with slot compare");

   property p_period_wrap;
      (ce_in && run_in && s_reg.active && s_reg.step == STEP_LAST && s_reg.slot == SLOT_LAST)
         |=> (s_reg.slot == 9'h000) && period_start_out;
   endproperty
   a_period_wrap: assert property (p_period_wrap)
      else $error("period did not wrap after last slot");

   property p_latch_boundary;
      (ce_in && run_in && s_reg.active
         && !(s_reg.step == STEP_LAST && s_reg.slot == SLOT_LAST))
         |=> $stable(s_reg.duty_lat);
   endproperty
   a_latch_boundary: assert property (p_latch_boundary)
      else $error("duty changed inside a period");

   property p_full_high;
      (s_reg.active && s_reg.duty_lat == DUTY_FULL) |-> pwm_out;
   endproperty
   a_full_high: assert property (p_full_high)
      else $error("full duty period shows a low phase");

   c_period: cover property (ce_in && period_start_out);

endmodule

// ===== bench/fan_switch_model.sv
/*
   Behavioural model of the low-side fan switch: the transistor conducts
   while its gate is high and the fan is then energised.
   Assumes the gate is driven by the PWM output on the same clock; it
   keeps a running count of energised clock cycles for duty measurement.
*/
module fan_switch_model (
   input  wire logic        ref_clk_in,
   input  wire logic        gate_in,
   output logic             fan_on_out,
   output logic [31:0]      on_cycles_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // a high gate closes the switch and puts full supply across the fan
   assign fan_on_out = gate_in;

   logic [31:0] on_cnt = 32'h0000_0000;

   assign on_cycles_out = on_cnt;

   // counted as a running total so a sliding window of one period gives duty
   always @(posedge ref_clk_in)
   begin
      if (fan_on_out === 1'b1)
      begin
         on_cnt <= on_cnt + 32'h0000_0001;
      end
   end
endmodule

// ===== bench/testbench.sv
/*
   Self-checking bench for the fan PWM duty controller: start-up, analog
   and register duty sources, over-temperature flag and shutdown.
   Assumes short STEP_CYCLES and START_CYCLES so one period is 600 cycles.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fan_pwm_pkg::*;

   localparam int STEP  = 2;
   localparam int START = 50;
   localparam int PER   = 300 * STEP;

   logic                 ref_clk_in = 1'b0;
   logic                 sys_rst_in = 1'b1;
   logic                 ce_in = 1'b1;
   logic                 shutdown_request_in = 1'b0;
   logic                 duty_source_select_in = 1'b0;
   duty_write_t          duty_write_in = '0;
   demand_t              demand_in = '{open: 1'b1, level: 9'h000};
   logic [3:0]           fan_duty_setting_out;
   logic                 pwm_drive_out;
   logic                 overtemp_flag_out;
   logic                 fault_drive_out;
   logic                 fault_oe_out;
   logic                 startup_active_out;
   logic                 period_start_out;
   logic                 fan_on;
   logic [31:0]          on_cycles;
   int                   n_mismatch = 0;
   int                   compares = 0;
   int                   k;

   always #5 ref_clk_in = ~ref_clk_in;

   fan_pwm_duty_control #(.STEP_CYCLES(STEP), .START_CYCLES(START)) DUT (
      .ref_clk_in            (ref_clk_in),
      .sys_rst_in            (sys_rst_in),
      .ce_in                 (ce_in),
      .shutdown_request_in   (shutdown_request_in),
      .duty_source_select_in (duty_source_select_in),
      .duty_write_in         (duty_write_in),
      .demand_in             (demand_in),
      .fan_duty_setting_out  (fan_duty_setting_out),
      .pwm_drive_out         (pwm_drive_out),
      .overtemp_flag_out     (overtemp_flag_out),
      .fault_drive_out       (fault_drive_out),
      .fault_oe_out          (fault_oe_out),
      .startup_active_out    (startup_active_out),
      .period_start_out      (period_start_out)
   );

   fan_switch_model fan_model (
      .ref_clk_in    (ref_clk_in),
      .gate_in       (pwm_drive_out),
      .fan_on_out    (fan_on),
      .on_cycles_out (on_cycles)
   );

   task automatic give_verdict();
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask

   // bounded wait for the next period boundary pulse
   task automatic wait_start();
      k = 0;
      do
      begin
         tick(1);
         k++;
      end
      while (period_start_out !== 1'b1 && k < PER + 10);
      check(16'(period_start_out), 16'h0001);
   endtask

   // energised cycles over one period, two boundaries after a duty change
   task automatic measure(input int slots);
      logic [31:0] c0;
      wait_start();
      wait_start();
      c0 = on_cycles;
      tick(PER);
      check(16'(on_cycles - c0), 16'(slots * STEP));
   endtask

   task automatic demand(input logic open, input int lvl);
      @(posedge ref_clk_in);
      demand_in <= '{open: open, level: 9'(lvl)};
   endtask

   task automatic write_code(input logic [3:0] code);
      @(posedge ref_clk_in);
      duty_write_in <= '{wr: 1'b1, code: code};
      @(posedge ref_clk_in);
      duty_write_in.wr <= 1'b0;
      tick(1);
      check(16'(fan_duty_setting_out), 16'(code));
   endtask

   // start-up: flag raised and full drive over START - 10 cycles of the start span
   task automatic startup_check();
      tick(2);
      check(16'(startup_active_out), 16'h0001);
      k = on_cycles;
      tick(START - 10);
      check(16'(on_cycles - k), 16'(START - 10));
   endtask

   function automatic int analog_slots(input int lvl);
      if (lvl <= 162)
         return 90;
      if (lvl >= 260)
         return 300;
      return 90 + (((lvl - 162) * 2194) >> 10);
   endfunction

   initial
   begin
      // about 26 measured spans of three periods each, with ample margin
      #900_000;
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      int lv[5] = '{100, 162, 200, 211, 259};
      repeat (16) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      #1;
      check(16'(fan_duty_setting_out), 16'h0002);
      startup_check();
      tick(20);
      check(16'(startup_active_out), 16'h0000);
      measure(118);
      for (int i = 0; i < 5; i++)
      begin
         demand(1'b0, lv[i]);
         measure(analog_slots(lv[i]));
      end
      demand(1'b0, 261);
      tick(3);
      check(16'(overtemp_flag_out), 16'h0001);
      check(16'({fault_oe_out, fault_drive_out}), 16'h0002);
      measure(300);
      demand(1'b0, 260);
      tick(3);
      check(16'({overtemp_flag_out, fault_oe_out}), 16'h0000);
      // host selects the register source before writing a code
      @(posedge ref_clk_in);
      duty_source_select_in <= 1'b1;
      for (int c = 0; c < 16; c++)
      begin
         write_code(4'(c));
         measure(90 + 14 * c);
      end
      // back to back writes: the last one holds
      @(posedge ref_clk_in);
      duty_write_in <= '{wr: 1'b1, code: 4'h3};
      @(posedge ref_clk_in);
      duty_write_in <= '{wr: 1'b1, code: 4'hA};
      @(posedge ref_clk_in);
      duty_write_in.wr <= 1'b0;
      tick(1);
      check(16'(fan_duty_setting_out), 16'h000A);
      // a write while the clock enable is low must be lost
      @(posedge ref_clk_in);
      ce_in            <= 1'b0;
      duty_write_in    <= '{wr: 1'b1, code: 4'h5};
      @(posedge ref_clk_in);
      duty_write_in.wr <= 1'b0;
      tick(1);
      check(16'(fan_duty_setting_out), 16'h000A);
      @(posedge ref_clk_in);
      ce_in <= 1'b1;
      measure(90 + 14 * 10);
      @(posedge ref_clk_in);
      duty_source_select_in <= 1'b0;
      measure(analog_slots(260));
      demand(1'b0, 300);
      @(posedge ref_clk_in);
      shutdown_request_in <= 1'b1;
      tick(3);
      check(16'({pwm_drive_out, startup_active_out}), 16'h0000);
      k = on_cycles;
      tick(PER);
      check(16'(on_cycles - k), 16'h0000);
      check(16'(overtemp_flag_out), 16'h0000);
      @(posedge ref_clk_in);
      shutdown_request_in <= 1'b0;
      demand(1'b1, 0);
      startup_check();
      check(16'(fan_duty_setting_out), 16'h000A);
      tick(20);
      measure(118);
      give_verdict();
   end
endmodule
